// *** rtl/cycle_timer.sv ***
// loadable down counter giving busy and last-cycle flags
`timescale 1ns/1ps
`default_nettype none
module cycle_timer
  import sdram_cmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // load
  input wire logic load,
  input wire logic [TIMER_W-1:0] load_val,
  // status
  output logic busy,
  output logic ending
);

  logic [TIMER_W-1:0] cnt_ff;
  logic [TIMER_W-1:0] nxt_cnt;

  assign nxt_cnt = load ? load_val : ((cnt_ff != '0) ? cnt_ff - TIMER_W'(1) : cnt_ff);
  assign busy = (cnt_ff != '0);
  assign ending = (cnt_ff <= TIMER_W'(1));

  always_ff @(posedge clock)
  begin
    if (srst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule
`default_nettype wire

// *** rtl/sdram_bank_legality.sv ***
// device end: bank state tracking and command legality judge
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_legality
  import sdram_cmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // command pins
  sdram_cmd_if.device_mp pins,
  // observed state
  output var bank_state_t bank_state_ff [BANKS],
  output logic illegal_ff,
  output logic auto_precharge_ff,
  output logic self_refresh_ff,
  output logic power_down_ff
);

  logic cke_prev_ff;
  cmd_t cmd;
  logic [BANK_W-1:0] sel_bank;
  bank_state_t sel_state;
  logic check_en;
  logic all_idle;
  logic illegal;
  logic legal;
  logic rrd_busy;
  logic rrd_load;
  logic ap_bit;
  logic enter_self;
  logic enter_down;
  bank_state_t nxt_state [BANKS];
  logic [BANKS-1:0] tmr_load;
  logic [BANKS-1:0] tmr_ending;
  logic [TIMER_W-1:0] tmr_val [BANKS];

  assign cmd = decode_cmd({pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n});
  assign sel_bank = pins.bank_select_field;
  assign sel_state = bank_state_ff[sel_bank];
  assign ap_bit = pins.addr[AUTO_PRECHARGE_BIT];
  assign check_en = cke_prev_ff && !self_refresh_ff && !power_down_ff;

  always_comb
  begin
    all_idle = 1'b1;
    for (int b = 0; b < BANKS; b++)
    begin
      if (bank_state_ff[b] != bank_idle)
        all_idle = 1'b0;
    end
  end

  // legality of the command against the addressed bank, or against all banks for mode set and refresh
  always_comb
  begin
    illegal = 1'b0;
    case (cmd)
      cmd_mode_set, cmd_refresh:
        illegal = !all_idle;
      cmd_precharge:
        illegal = (sel_state == bank_refreshing) || (sel_state == bank_mode_access);
      cmd_activate:
        illegal = (sel_state != bank_idle) || rrd_busy;
      cmd_write, cmd_read, cmd_burst_stop:
        illegal = (sel_state != bank_row_active);
      default:
        illegal = 1'b0;
    endcase
  end

  assign legal = check_en && !illegal;
  assign rrd_load = legal && (cmd == cmd_activate);
  assign enter_self = legal && (cmd == cmd_refresh) && !pins.cke;
  assign enter_down = check_en && (cmd == cmd_deselect) && all_idle && !pins.cke;

  // next state of every bank
  always_comb
  begin
    for (int b = 0; b < BANKS; b++)
    begin
      nxt_state[b] = bank_state_ff[b];
      tmr_load[b] = 1'b0;
      tmr_val[b] = '0;
      if (legal && (cmd == cmd_mode_set))
      begin
        nxt_state[b] = bank_mode_access;
        tmr_load[b] = 1'b1;
        tmr_val[b] = timer_load(MODE_ACCESS_CYCLES);
      end
      else if (legal && (cmd == cmd_refresh) && pins.cke)
      begin
        nxt_state[b] = bank_refreshing;
        tmr_load[b] = 1'b1;
        tmr_val[b] = timer_load(BANK_CYCLE_CYC);
      end
      else if (legal && (BANK_W'(b) == sel_bank) && (cmd == cmd_activate))
      begin
        nxt_state[b] = bank_row_active;
      end
      else if (legal && (BANK_W'(b) == sel_bank) && (bank_state_ff[b] == bank_row_active)
               && ((cmd == cmd_precharge) || (((cmd == cmd_read) || (cmd == cmd_write)) && ap_bit)))
      begin
        nxt_state[b] = bank_precharging;
        tmr_load[b] = 1'b1;
        tmr_val[b] = timer_load(PRECHARGE_CYC);
      end
      else if (((bank_state_ff[b] == bank_refreshing) || (bank_state_ff[b] == bank_mode_access)
               || (bank_state_ff[b] == bank_precharging)) && tmr_ending[b])
      begin
        nxt_state[b] = bank_idle;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      for (int b = 0; b < BANKS; b++)
        bank_state_ff[b] <= BANK_STATE_RESET;
    end
    else
    begin
      for (int b = 0; b < BANKS; b++)
        bank_state_ff[b] <= nxt_state[b];
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cke_prev_ff <= CKE_RESET;
      illegal_ff <= 1'b0;
    end
    else
    begin
      cke_prev_ff <= pins.cke;
      illegal_ff <= check_en && illegal;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      auto_precharge_ff <= 1'b0;
    else if (legal && ((cmd == cmd_read) || (cmd == cmd_write)))
      auto_precharge_ff <= ap_bit;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      self_refresh_ff <= 1'b0;
    else if (enter_self)
      self_refresh_ff <= 1'b1;
    else if (pins.cke)
      self_refresh_ff <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      power_down_ff <= 1'b0;
    else if (enter_down)
      power_down_ff <= 1'b1;
    else if (pins.cke)
      power_down_ff <= 1'b0;
  end

  // one timer per bank for the timed states
  for (genvar g = 0; g < BANKS; g++)
  begin : g_bank
    cycle_timer u_state_timer (
      .clock(clock),
      .srst(srst),
      .load(tmr_load[g]),
      .load_val(tmr_val[g]),
      .busy(),
      .ending(tmr_ending[g])
    );
  end

  // spacing between activates to any two banks
  cycle_timer u_rrd_timer (
    .clock(clock),
    .srst(srst),
    .load(rrd_load),
    .load_val(timer_load(BANK_TO_BANK_CYC)),
    .busy(rrd_busy),
    .ending()
  );

endmodule
`default_nettype wire

// *** rtl/sdram_cmd_if.sv ***
// command pins between the memory controller and the device
`timescale 1ns/1ps
`default_nettype none
interface sdram_cmd_if;
  import sdram_cmd_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BANK_W-1:0] bank_select_field;
  logic [ADDR_W-1:0] addr;
  modport device_mp (
    input cke, cs_n, ras_n, cas_n, we_n, bank_select_field, addr
  );
  modport controller_mp (
    output cke, cs_n, ras_n, cas_n, we_n, bank_select_field, addr
  );
endinterface
`default_nettype wire

// *** rtl/sdram_cmd_issuer.sv ***
// controller end: issues only commands that meet state and spacing
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_issuer
  import sdram_cmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // user requests
  input wire logic req_valid,
  input wire cmd_t req_cmd,
  input wire logic [BANK_W-1:0] req_bank,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic low_power,
  output logic req_ready,
  // status
  output logic [BANKS-1:0] ras_overdue_ff,
  // command pins
  sdram_cmd_if.controller_mp pins
);

  logic [3:0] pin_code_ff;
  logic [BANK_W-1:0] bank_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic cke_ff;
  logic [BANKS-1:0] open_ff;
  logic [BANKS-1:0] nxt_open;
  logic [BANKS-1:0] bank_free;
  logic [BANKS-1:0] closed_ff;
  logic [BANKS-1:0] busy [TMR_KINDS];
  logic [BANKS-1:0] tload [TMR_KINDS];
  logic all_free;
  logic sel_open;
  logic ok;
  logic take;
  logic glob_busy;
  logic glob_load;
  logic [TIMER_W-1:0] glob_val;
  logic rrd_busy;
  logic is_nop;
  logic closes;

  assign is_nop = (req_cmd == cmd_nop) || (req_cmd == cmd_deselect);
  assign sel_open = open_ff[req_bank];
  assign all_free = (&bank_free) && !glob_busy;
  assign closes = (req_cmd == cmd_precharge) ||
                  (((req_cmd == cmd_read) || (req_cmd == cmd_write)) && req_addr[AUTO_PRECHARGE_BIT]);

  for (genvar g = 0; g < BANKS; g++)
  begin : g_free
    // device shows precharging for at least one cycle after the close is seen
    assign bank_free[g] = !open_ff[g] && !busy[K_PRE][g] && !closed_ff[g];
  end

  always_comb
  begin
    ok = 1'b1;
    case (req_cmd)
      cmd_mode_set, cmd_refresh:
        ok = all_free;
      cmd_activate:
        ok = bank_free[req_bank] && !rrd_busy;
      cmd_write, cmd_read, cmd_burst_stop:
        ok = sel_open && !busy[K_COL][req_bank];
      cmd_precharge:
        ok = !sel_open || (!busy[K_RAS_MIN][req_bank] && !busy[K_WR][req_bank]);
      default:
        ok = 1'b1;
    endcase
  end

  // refresh, mode access and low power admit nothing but nop and deselect
  assign req_ready = is_nop || (ok && !glob_busy && cke_ff);
  assign take = req_valid && req_ready;
  assign glob_load = take && ((req_cmd == cmd_mode_set) || (req_cmd == cmd_refresh));
  assign glob_val = (req_cmd == cmd_mode_set) ? timer_load(MODE_ACCESS_CYCLES)
                                              : timer_load(BANK_CYCLE_CYC);

  always_comb
  begin
    nxt_open = open_ff;
    for (int k = 0; k < TMR_KINDS; k++)
      tload[k] = '0;
    for (int b = 0; b < BANKS; b++)
    begin
      if (take && (BANK_W'(b) == req_bank))
      begin
        if (req_cmd == cmd_activate)
        begin
          nxt_open[b] = 1'b1;
          tload[K_COL][b] = 1'b1;
          tload[K_RAS_MIN][b] = 1'b1;
          tload[K_RAS_MAX][b] = 1'b1;
        end
        if (req_cmd == cmd_write)
          tload[K_WR][b] = 1'b1;
        if (closes && open_ff[b])
        begin
          nxt_open[b] = 1'b0;
          tload[K_PRE][b] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pin_code_ff <= PINS_RESET;
      bank_ff <= '0;
      addr_ff <= '0;
      cke_ff <= CKE_RESET;
      open_ff <= '0;
      closed_ff <= '0;
    end
    else
    begin
      pin_code_ff <= take ? encode_cmd(req_cmd) : encode_cmd(cmd_nop);
      bank_ff <= take ? req_bank : bank_ff;
      addr_ff <= take ? req_addr : addr_ff;
      cke_ff <= !low_power;
      open_ff <= nxt_open;
      closed_ff <= open_ff & ~nxt_open;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      ras_overdue_ff <= '0;
    else
      ras_overdue_ff <= open_ff & ~busy[K_RAS_MAX];
  end

  assign pins.cs_n = pin_code_ff[3];
  assign pins.ras_n = pin_code_ff[2];
  assign pins.cas_n = pin_code_ff[1];
  assign pins.we_n = pin_code_ff[0];
  assign pins.bank_select_field = bank_ff;
  assign pins.addr = addr_ff;
  assign pins.cke = cke_ff;

  for (genvar k = 0; k < TMR_KINDS; k++)
  begin : g_kind
    for (genvar g = 0; g < BANKS; g++)
    begin : g_bank
      cycle_timer u_timer (
        .clock(clock),
        .srst(srst),
        .load(tload[k][g]),
        .load_val(kind_load(k)),
        .busy(busy[k][g]),
        .ending()
      );
    end
  end

  cycle_timer u_glob_timer (
    .clock(clock),
    .srst(srst),
    .load(glob_load),
    .load_val(glob_val),
    .busy(glob_busy),
    .ending()
  );

  cycle_timer u_rrd_timer (
    .clock(clock),
    .srst(srst),
    .load(take && (req_cmd == cmd_activate)),
    .load_val(timer_load(BANK_TO_BANK_CYC)),
    .busy(rrd_busy),
    .ending()
  );

endmodule
`default_nettype wire

// *** rtl/sdram_cmd_pkg.sv ***
// shared constants, types and command coding for the bank legality pair
package sdram_cmd_pkg;

  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 13;
  localparam int AUTO_PRECHARGE_BIT = 10;
  localparam int TIMER_W = 12;

  // timing in ns at the documented figures, mode access in cycles, clock at 20 MHz
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int BANK_CYCLE_TIME_NS = 70;
  localparam int ROW_ACTIVE_MIN_NS = 50;
  localparam int ROW_ACTIVE_MAX_NS = 100000;
  localparam int ACT_TO_COL_NS = 20;
  localparam int BANK_TO_BANK_NS = 20;
  localparam int PRECHARGE_NS = 20;
  localparam int WRITE_RECOVERY_NS = 20;
  localparam int MODE_ACCESS_CYCLES = 2;

  // least times round up, longest times round down, never below one cycle
  function automatic int least_cycles(input int ns);
    int c;
    c = (ns + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int longest_cycles(input int ns);
    int c;
    c = ns / CLOCK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int BANK_CYCLE_CYC = least_cycles(BANK_CYCLE_TIME_NS);
  localparam int ROW_ACTIVE_MIN_CYC = least_cycles(ROW_ACTIVE_MIN_NS);
  localparam int ROW_ACTIVE_MAX_CYC = longest_cycles(ROW_ACTIVE_MAX_NS);
  localparam int ACT_TO_COL_CYC = least_cycles(ACT_TO_COL_NS);
  localparam int BANK_TO_BANK_CYC = least_cycles(BANK_TO_BANK_NS);
  localparam int PRECHARGE_CYC = least_cycles(PRECHARGE_NS);
  localparam int WRITE_RECOVERY_CYC = least_cycles(WRITE_RECOVERY_NS);

  // a timer loaded with n-1 is busy for the n-1 cycles after the command
  function automatic logic [TIMER_W-1:0] timer_load(input int cycles);
    return TIMER_W'(cycles - 1);
  endfunction

  // per-bank timer kinds kept by the controller end
  localparam int TMR_KINDS = 5;
  localparam int K_COL = 0;
  localparam int K_RAS_MIN = 1;
  localparam int K_RAS_MAX = 2;
  localparam int K_WR = 3;
  localparam int K_PRE = 4;

  function automatic logic [TIMER_W-1:0] kind_load(input int k);
    case (k)
      K_COL: return timer_load(ACT_TO_COL_CYC);
      K_RAS_MIN: return timer_load(ROW_ACTIVE_MIN_CYC);
      K_RAS_MAX: return timer_load(ROW_ACTIVE_MAX_CYC);
      K_WR: return timer_load(WRITE_RECOVERY_CYC);
      default: return timer_load(PRECHARGE_CYC);
    endcase
  endfunction

  typedef enum logic [2:0] {
    bank_idle,
    bank_row_active,
    bank_precharging,
    bank_refreshing,
    bank_mode_access
  } bank_state_t;

  typedef enum logic [3:0] {
    cmd_deselect,
    cmd_nop,
    cmd_mode_set,
    cmd_refresh,
    cmd_precharge,
    cmd_activate,
    cmd_write,
    cmd_read,
    cmd_burst_stop
  } cmd_t;

  localparam bank_state_t BANK_STATE_RESET = bank_idle;
  localparam logic [3:0] PINS_RESET = 4'h7;
  localparam logic CKE_RESET = 1'b1;

  // pins are {cs_n, ras_n, cas_n, we_n}
  function automatic cmd_t decode_cmd(input logic [3:0] p);
    if (p[3])
      return cmd_deselect;
    case (p[2:0])
      3'h0: return cmd_mode_set;
      3'h1: return cmd_refresh;
      3'h2: return cmd_precharge;
      3'h3: return cmd_activate;
      3'h4: return cmd_write;
      3'h5: return cmd_read;
      3'h6: return cmd_burst_stop;
      default: return cmd_nop;
    endcase
  endfunction

  function automatic logic [3:0] encode_cmd(input cmd_t c);
    case (c)
      cmd_deselect: return 4'h8;
      cmd_mode_set: return 4'h0;
      cmd_refresh: return 4'h1;
      cmd_precharge: return 4'h2;
      cmd_activate: return 4'h3;
      cmd_write: return 4'h4;
      cmd_read: return 4'h5;
      cmd_burst_stop: return 4'h6;
      default: return 4'h7;
    endcase
  endfunction

endpackage

// *** verification/sdram_cmd_props.sv ***
// pin-level checks of the command stream between the two ends
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_props
  import sdram_cmd_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BANK_W-1:0] bank_select_field,
  input wire logic [ADDR_W-1:0] addr
);
  logic [3:0] p;
  logic quiet;
  logic col;
  logic ap;
  logic [BANKS-1:0] sel;
  logic [BANKS-1:0] open_ff;
  logic [BANKS-1:0] shut_ff;
  logic [BANKS-1:0] nxt_open;
  logic [BANKS-1:0] nxt_shut;
  assign p = {cs_n, ras_n, cas_n, we_n};
  assign quiet = cs_n || (p == 4'h7);
  assign col = (p == 4'h4) || (p == 4'h5) || (p == 4'h6);
  assign ap = ((p == 4'h4) || (p == 4'h5)) && addr[AUTO_PRECHARGE_BIT];
  assign sel = BANKS'(1) << bank_select_field;
  assign nxt_shut = ((p == 4'h2) || ap) ? (open_ff & sel) : '0;
  assign nxt_open = (p == 4'h3) ? (open_ff | sel) : (open_ff & ~nxt_shut);
  // open rows and rows closing this cycle
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      open_ff <= '0;
      shut_ff <= '0;
    end
    else
    begin
      open_ff <= nxt_open;
      shut_ff <= nxt_shut;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence s_quiet;
    quiet;
  endsequence
  sequence s_all_idle;
    (open_ff == '0) && (shut_ff == '0);
  endsequence
  chk_refresh_then_quiet: assert property (p == 4'h1 && cke |=> s_quiet)
    else $error("command while refreshing");
  chk_mode_then_quiet: assert property (p == 4'h0 |=> s_quiet)
    else $error("command while mode access");
  chk_refresh_all_idle: assert property (p == 4'h1 |-> s_all_idle)
    else $error("refresh with a bank busy");
  chk_mode_all_idle: assert property (p == 4'h0 |-> s_all_idle)
    else $error("mode set with a bank busy");
  chk_col_needs_open: assert property (col |-> open_ff[bank_select_field])
    else $error("column command to closed bank");
  chk_act_bank_closed: assert property (p == 4'h3 |-> !(open_ff[bank_select_field] || shut_ff[bank_select_field]))
    else $error("activate to busy bank");
  chk_cke_low_quiet: assert property (!$past(cke) |-> s_quiet)
    else $error("command after clock enable low");
  chk_ap_no_reuse: assert property (ap |=> !(col && bank_select_field == $past(bank_select_field)))
    else $error("access right after auto precharge");
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench: issuer drives one device, bench drives a second
`timescale 1ns/1ps
`default_nettype none
`define CK(nm, e, g) \
  begin \
    cmp_count++; \
    if ((g) !== (e)) \
    begin \
      n_fail++; \
      $display("unexpected %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module tb_top;
  import sdram_cmd_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  cmd_t req_cmd = cmd_nop;
  logic [BANK_W-1:0] req_bank = '0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic low_power = 1'b0;
  logic req_ready;
  logic [BANKS-1:0] ras_overdue_ff;
  bank_state_t st_a [BANKS];
  bank_state_t st_b [BANKS];
  logic ill_a, ap_a, sr_a, pd_a, ill_b, ap_b, sr_b, pd_b;
  logic [16:0] rnd = 17'h11f81;
  logic [1:0] bk;
  logic a10;
  cmd_t c;
  logic [BANKS-1:0] open_m = '0;
  int n_fail = 0;
  int cmp_count = 0;
  sdram_cmd_if ifa();
  sdram_cmd_if ifb();
  sdram_cmd_issuer sdram_cmd_issuer_i (.clock(clock), .srst(srst), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .low_power(low_power),
    .req_ready(req_ready), .ras_overdue_ff(ras_overdue_ff), .pins(ifa));
  sdram_bank_legality sdram_bank_legality_i (.clock(clock), .srst(srst), .pins(ifa),
    .bank_state_ff(st_a), .illegal_ff(ill_a), .auto_precharge_ff(ap_a),
    .self_refresh_ff(sr_a), .power_down_ff(pd_a));
  sdram_bank_legality rogue_sdram_bank_legality_i (.clock(clock), .srst(srst), .pins(ifb),
    .bank_state_ff(st_b), .illegal_ff(ill_b), .auto_precharge_ff(ap_b),
    .self_refresh_ff(sr_b), .power_down_ff(pd_b));
  sdram_cmd_props sdram_cmd_props_i (.clock(clock), .srst(srst), .cke(ifa.cke),
    .cs_n(ifa.cs_n), .ras_n(ifa.ras_n), .cas_n(ifa.cas_n), .we_n(ifa.we_n),
    .bank_select_field(ifa.bank_select_field), .addr(ifa.addr));
  initial
  begin
    forever #25 clock = ~clock;
  end
  function automatic logic [16:0] lfsr(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function automatic bank_state_t exp_state(input cmd_t k, input logic a);
    if (k == cmd_activate || ((k == cmd_read || k == cmd_write) && !a))
      return bank_row_active;
    return bank_precharging;
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic tick();
    @(posedge clock);
    #2;
  endtask
  task automatic bcmd(input logic [3:0] p, input logic [1:0] b, input logic a, input logic ck);
    {ifb.cs_n, ifb.ras_n, ifb.cas_n, ifb.we_n} = p;
    ifb.bank_select_field = b;
    ifb.addr = {2'h0, a, 10'h000};
    ifb.cke = ck;
    tick();
  endtask
  task automatic req(input cmd_t k, input logic [1:0] b, input logic a);
    int n;
    req_valid = 1'b1;
    req_cmd = k;
    req_bank = b;
    req_addr = {2'h0, a, 10'h000};
    #1;
    n = 0;
    while (req_ready !== 1'b1 && n < 300)
    begin
      tick();
      n++;
    end
    if (n == 300)
    begin
      n_fail++;
      wrap_up();
    end
    tick();
    req_valid = 1'b0;
    tick();
  endtask
  task automatic close_all();
    for (int i = 0; i < BANKS; i++)
      if (open_m[i])
        req(cmd_precharge, 2'(i), 1'b0);
    open_m = '0;
  endtask
  always @(negedge clock)
    if (!srst)
      `CK("illegal", 1'b0, ill_a)
  initial
  begin
    ifb.cke = 1'b1;
    {ifb.cs_n, ifb.ras_n, ifb.cas_n, ifb.we_n} = 4'h7;
    ifb.bank_select_field = '0;
    ifb.addr = '0;
    repeat (6) @(posedge clock);
    #2;
    srst = 1'b0;
    tick();
    // rule breaking on the second link
    bcmd(4'h3, 2'h2, 1'b0, 1'b1);
    `CK("st2", bank_row_active, st_b[2])
    bcmd(4'h3, 2'h1, 1'b0, 1'b1);
    `CK("ill", 1'b0, ill_b)
    bcmd(4'h5, 2'h0, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    `CK("st0", bank_idle, st_b[0])
    bcmd(4'h6, 2'h0, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    bcmd(4'h3, 2'h2, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    `CK("st2", bank_row_active, st_b[2])
    bcmd(4'h1, 2'h0, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    bcmd(4'h4, 2'h2, 1'b1, 1'b1);
    `CK("ap", 1'b1, ap_b)
    `CK("st2", bank_precharging, st_b[2])
    bcmd(4'h2, 2'h1, 1'b0, 1'b1);
    `CK("st1", bank_precharging, st_b[1])
    bcmd(4'h7, 2'h0, 1'b0, 1'b1);
    bcmd(4'h1, 2'h0, 1'b0, 1'b1);
    `CK("ill", 1'b0, ill_b)
    `CK("st3", bank_refreshing, st_b[3])
    bcmd(4'h3, 2'h1, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    `CK("st1", bank_idle, st_b[1])
    bcmd(4'h0, 2'h0, 1'b0, 1'b1);
    `CK("st3", bank_mode_access, st_b[3])
    bcmd(4'h2, 2'h3, 1'b0, 1'b1);
    `CK("ill", 1'b1, ill_b)
    `CK("st3", bank_idle, st_b[3])
    bcmd(4'h8, 2'h0, 1'b0, 1'b1);
    `CK("pd", 1'b0, pd_b)
    bcmd(4'h1, 2'h0, 1'b0, 1'b0);
    `CK("sr", 1'b1, sr_b)
    `CK("st0", bank_idle, st_b[0])
    bcmd(4'h3, 2'h0, 1'b0, 1'b0);
    `CK("ill", 1'b0, ill_b)
    `CK("st0", bank_idle, st_b[0])
    bcmd(4'h7, 2'h0, 1'b0, 1'b1);
    bcmd(4'h7, 2'h0, 1'b0, 1'b1);
    `CK("sr", 1'b0, sr_b)
    bcmd(4'h8, 2'h0, 1'b0, 1'b0);
    `CK("pd", 1'b1, pd_b)
    bcmd(4'h7, 2'h0, 1'b0, 1'b1);
    bcmd(4'h7, 2'h0, 1'b0, 1'b1);
    `CK("pd", 1'b0, pd_b)
    // issuer traffic on the first link
    req(cmd_activate, 2'h0, 1'b0);
    repeat (ROW_ACTIVE_MAX_CYC + 3) tick();
    `CK("overdue", 1'b1, ras_overdue_ff[0])
    req(cmd_precharge, 2'h0, 1'b0);
    `CK("overdue", 4'h0, ras_overdue_ff)
    repeat (200)
    begin
      rnd = lfsr(rnd);
      bk = rnd[1:0];
      a10 = rnd[2];
      if (!open_m[bk])
        c = cmd_activate;
      else if (rnd[4:3] == 2'h0)
        c = cmd_precharge;
      else
        c = rnd[5] ? cmd_read : cmd_write;
      if (c == cmd_precharge)
        a10 = 1'b0;
      req(c, bk, a10);
      `CK("state", exp_state(c, a10), st_a[bk])
      if (c == cmd_read || c == cmd_write)
        `CK("ap", a10, ap_a)
      open_m[bk] = (exp_state(c, a10) == bank_row_active);
      if (rnd[8:6] == 3'h0)
      begin
        close_all();
        req(rnd[9] ? cmd_refresh : cmd_mode_set, 2'h0, 1'b0);
        `CK("st3", rnd[9] ? bank_refreshing : bank_mode_access, st_a[3])
      end
    end
    close_all();
    repeat (4) tick();
    low_power = 1'b1;
    req(cmd_refresh, 2'h0, 1'b0);
    `CK("sr", 1'b1, sr_a)
    `CK("ready", 1'b0, req_ready)
    low_power = 1'b0;
    repeat (4) tick();
    `CK("sr", 1'b0, sr_a)
    wrap_up();
  end
endmodule
`default_nettype wire
